// *** ccsr_defs.svh ***
`ifndef CCSR_DEFS_SVH
`define CCSR_DEFS_SVH

// ----------------------------------------------------------------------------
// command codes and lengths
// ----------------------------------------------------------------------------
`define CCSR_CMD_STATUS      8'h43
`define CCSR_LEN_STATUS      8'h02
`define CCSR_CMD_SET_SELECT  8'h47
`define CCSR_LEN_SET_SELECT  8'h01
`define CCSR_CMD_BITRATE     8'h44
`define CCSR_LEN_BITRATE     8'h04
`define CCSR_CMD_RESET       8'h42
`define CCSR_LEN_RESET       8'h02
`define CCSR_DIR_REPLY       1'h0

// ----------------------------------------------------------------------------
// first reply byte, bit positions
// ----------------------------------------------------------------------------
`define CCSR_B1_NO_TRIG      0
`define CCSR_B1_RESET_SEEN   1
`define CCSR_B1_UNLOCKED     2
`define CCSR_B1_RSVD3        3
`define CCSR_B1_UNKNOWN_CMD  4
`define CCSR_B1_DENIED       5
`define CCSR_B1_LEN_ERR      6
`define CCSR_B1_PARAM_ERR    7

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define CCSR_FLAGS_RESET     16'h0000
`define CCSR_BYTE_ZERO       8'h00
`define CCSR_CLK_KHZ         250000
`define CCSR_TRIG_TIMEOUT_MS 5000

`endif

// *** ccsr_pkg.sv ***
`default_nettype none
package ccsr_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_BYTE1, ST_BYTE2} ccsr_state_t;
endpackage : ccsr_pkg
`default_nettype wire

// *** ccsr_trig_watch.sv ***
`default_nettype none
`include "ccsr_defs.svh"
module ccsr_trig_watch #(
    parameter int unsigned TICK_CYCLES   = `CCSR_CLK_KHZ,
    parameter int unsigned TIMEOUT_TICKS = `CCSR_TRIG_TIMEOUT_MS
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // trigger in, flag out
    input  wire logic external_line_trigger,
    output var  logic trig_missing_r
);
    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
    localparam int unsigned MW = $clog2(TIMEOUT_TICKS + 1);

    logic [TW-1:0] div_r;
    logic [MW-1:0] ms_r;
    logic          tick;

    // ------------------------------------------------------------------------
    // millisecond enable and timeout count
    // ------------------------------------------------------------------------
    assign tick = (div_r == TW'(TICK_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (rst || external_line_trigger || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + TW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || external_line_trigger) begin
            ms_r           <= '0;
            trig_missing_r <= 1'b0;
        end else if (tick && ms_r != MW'(TIMEOUT_TICKS)) begin
            ms_r <= ms_r + MW'(1);
        end else if (ms_r == MW'(TIMEOUT_TICKS)) begin
            trig_missing_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    a_trig_clears: assert property (@(posedge clk_sys) disable iff (rst)
        external_line_trigger |=> !trig_missing_r [*2])
        else $error("missing-trigger flag not cleared by trigger");
    a_trig_timeout: assert property (@(posedge clk_sys) disable iff (rst)
        (ms_r == MW'(TIMEOUT_TICKS) && !external_line_trigger) |=> trig_missing_r)
        else $error("missing-trigger flag not set at timeout");
    c_trig_timeout: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(trig_missing_r));
endmodule : ccsr_trig_watch
`default_nettype wire

// *** ccsr_status.sv ***
`default_nettype none
`include "ccsr_defs.svh"
module ccsr_status
    import ccsr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES   = `CCSR_CLK_KHZ,
    parameter int unsigned TIMEOUT_TICKS = `CCSR_TRIG_TIMEOUT_MS
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // decoded command header
    input  wire logic       cmd_valid,
    output var  logic       cmd_ready_r,
    input  wire logic [7:0] cmd_code,
    input  wire logic       cmd_read,
    input  wire logic [7:0] cmd_len,
    // reply header and data bytes
    output var  logic [7:0] rsp_code_r,
    output var  logic       rsp_read_r,
    output var  logic [7:0] rsp_len_r,
    output var  logic       tx_valid_r,
    input  wire logic       tx_ready,
    output var  logic [7:0] tx_data_r,
    output var  logic       tx_last_r,
    // camera conditions
    input  wire logic       external_line_trigger,
    input  wire logic       camera_unlocked,
    input  wire logic       flags_clear,
    input  wire logic       logic_general_err,
    input  wire logic       logic_image_missing,
    input  wire logic       converter_link_err,
    input  wire logic       cmd_list_entry_err,
    input  wire logic       user_set_corrupt,
    input  wire logic       factory_set_corrupt,
    input  wire logic       nvm_checksum_err,
    input  wire logic       nvm_cmd_list_missing,
    // register view
    output var  logic [15:0] camera_error_flags_r
);
    ccsr_state_t state_r;
    logic        trig_missing_r;
    logic        reset_seen_r;
    logic        unknown_r;
    logic        denied_r;
    logic        len_err_r;
    logic [7:0]  snap_b2_r;
    logic        take;
    logic        known;
    logic        len_ok;
    logic        access_ok;
    logic        run_status;
    logic [7:0]  flags_b1;
    logic [7:0]  flags_b2;

    // ------------------------------------------------------------------------
    // command table
    // ------------------------------------------------------------------------
    function automatic logic code_known(input logic [7:0] code);
        code_known = (code == `CCSR_CMD_STATUS) || (code == `CCSR_CMD_SET_SELECT)
                  || (code == `CCSR_CMD_BITRATE) || (code == `CCSR_CMD_RESET);
    endfunction : code_known

    function automatic logic [7:0] code_len(input logic [7:0] code);
        unique case (code)
            `CCSR_CMD_STATUS:     code_len = `CCSR_LEN_STATUS;
            `CCSR_CMD_SET_SELECT: code_len = `CCSR_LEN_SET_SELECT;
            `CCSR_CMD_BITRATE:    code_len = `CCSR_LEN_BITRATE;
            `CCSR_CMD_RESET:      code_len = `CCSR_LEN_RESET;
            default:              code_len = `CCSR_BYTE_ZERO;
        endcase
    endfunction : code_len

    // status is read only; bitrate and reset are write only
    function automatic logic dir_allowed(input logic [7:0] code, input logic rd);
        unique case (code)
            `CCSR_CMD_STATUS:  dir_allowed = rd;
            `CCSR_CMD_BITRATE,
            `CCSR_CMD_RESET:   dir_allowed = !rd;
            default:           dir_allowed = 1'b1;
        endcase
    endfunction : dir_allowed

    assign take       = cmd_valid && cmd_ready_r;
    assign known      = code_known(cmd_code);
    assign len_ok     = (cmd_len == code_len(cmd_code));
    assign access_ok  = dir_allowed(cmd_code, cmd_read);
    assign run_status = take && known && len_ok && access_ok
                     && (cmd_code == `CCSR_CMD_STATUS);

    // ------------------------------------------------------------------------
    // flag bytes
    // ------------------------------------------------------------------------
    always_comb begin
        flags_b1                       = `CCSR_BYTE_ZERO;
        flags_b1[`CCSR_B1_NO_TRIG]     = trig_missing_r;
        flags_b1[`CCSR_B1_RESET_SEEN]  = reset_seen_r;
        flags_b1[`CCSR_B1_UNLOCKED]    = camera_unlocked;
        flags_b1[`CCSR_B1_RSVD3]       = 1'b0;
        flags_b1[`CCSR_B1_UNKNOWN_CMD] = unknown_r;
        flags_b1[`CCSR_B1_DENIED]      = denied_r;
        flags_b1[`CCSR_B1_LEN_ERR]     = len_err_r;
        flags_b1[`CCSR_B1_PARAM_ERR]   = 1'b0;
    end

    assign flags_b2 = {nvm_cmd_list_missing, nvm_checksum_err,
                       factory_set_corrupt, user_set_corrupt,
                       cmd_list_entry_err, converter_link_err,
                       logic_image_missing, logic_general_err};

    ccsr_trig_watch #(
        .TICK_CYCLES   (TICK_CYCLES),
        .TIMEOUT_TICKS (TIMEOUT_TICKS)
    ) u_trig_watch (
        .clk_sys               (clk_sys),
        .rst                   (rst),
        .external_line_trigger (external_line_trigger),
        .trig_missing_r        (trig_missing_r)
    );

    // ------------------------------------------------------------------------
    // sticky error flags, set wins over clear
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reset_seen_r <= 1'b1;
        end else if (flags_clear) begin
            reset_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            unknown_r <= 1'b0;
            denied_r  <= 1'b0;
        end else begin
            if (take && !known) begin
                unknown_r <= 1'b1;
            end else if (flags_clear) begin
                unknown_r <= 1'b0;
            end
            if (take && known && !access_ok) begin
                denied_r <= 1'b1;
            end else if (flags_clear) begin
                denied_r <= 1'b0;
            end
        end
    end

    // length check follows the most recent command
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            len_err_r <= 1'b0;
        end else if (take) begin
            len_err_r <= known && !len_ok;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            camera_error_flags_r <= `CCSR_FLAGS_RESET;
        end else begin
            camera_error_flags_r <= {flags_b2, flags_b1};
        end
    end

    // ------------------------------------------------------------------------
    // reply sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            cmd_ready_r <= 1'b1;
            tx_valid_r  <= 1'b0;
            tx_last_r   <= 1'b0;
            tx_data_r   <= `CCSR_BYTE_ZERO;
            snap_b2_r   <= `CCSR_BYTE_ZERO;
            rsp_code_r  <= `CCSR_BYTE_ZERO;
            rsp_read_r  <= `CCSR_DIR_REPLY;
            rsp_len_r   <= `CCSR_BYTE_ZERO;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (run_status) begin
                        state_r     <= ST_BYTE1;
                        cmd_ready_r <= 1'b0;
                        tx_valid_r  <= 1'b1;
                        tx_last_r   <= 1'b0;
                        tx_data_r   <= flags_b1;
                        snap_b2_r   <= flags_b2;
                        rsp_code_r  <= `CCSR_CMD_STATUS;
                        rsp_read_r  <= `CCSR_DIR_REPLY;
                        rsp_len_r   <= `CCSR_LEN_STATUS;
                    end
                end
                ST_BYTE1: begin
                    if (tx_ready) begin
                        state_r   <= ST_BYTE2;
                        tx_data_r <= snap_b2_r;
                        tx_last_r <= 1'b1;
                    end
                end
                ST_BYTE2: begin
                    if (tx_ready) begin
                        state_r     <= ST_IDLE;
                        cmd_ready_r <= 1'b1;
                        tx_valid_r  <= 1'b0;
                        tx_last_r   <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    a_reply_header: assert property (@(posedge clk_sys) disable iff (rst)
        tx_valid_r |-> (rsp_code_r == `CCSR_CMD_STATUS && rsp_read_r == `CCSR_DIR_REPLY
                        && rsp_len_r == `CCSR_LEN_STATUS))
        else $error("reply header wrong");
    a_reply_starts: assert property (@(posedge clk_sys) disable iff (rst)
        run_status |=> tx_valid_r && !tx_last_r && tx_data_r == $past(flags_b1))
        else $error("first reply byte missing or wrong");
    a_byte_order: assert property (@(posedge clk_sys) disable iff (rst)
        (tx_valid_r && !tx_last_r && tx_ready) |=> tx_valid_r && tx_last_r)
        else $error("second reply byte out of order");
    a_reply_ends: assert property (@(posedge clk_sys) disable iff (rst)
        (tx_valid_r && tx_last_r && tx_ready) |=> !tx_valid_r && !tx_last_r && cmd_ready_r)
        else $error("reply does not end after second byte");
    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (tx_valid_r && !tx_last_r) |-> !tx_data_r[`CCSR_B1_RSVD3]
                                      && !tx_data_r[`CCSR_B1_PARAM_ERR])
        else $error("reserved flag bit set");
    a_unlock_bit: assert property (@(posedge clk_sys) disable iff (rst)
        run_status |=> tx_data_r[`CCSR_B1_UNLOCKED] == $past(camera_unlocked))
        else $error("unlock bit does not follow state");
    a_unknown_set: assert property (@(posedge clk_sys) disable iff (rst)
        (take && !known) |=> unknown_r && !tx_valid_r)
        else $error("unknown code not flagged");
    a_denied_set: assert property (@(posedge clk_sys) disable iff (rst)
        (take && known && !access_ok) |=> denied_r && !tx_valid_r)
        else $error("denied access not flagged");
    a_len_check: assert property (@(posedge clk_sys) disable iff (rst)
        take |=> len_err_r == $past(known && !len_ok))
        else $error("length flag wrong");
    a_byte2_map: assert property (@(posedge clk_sys) disable iff (rst)
        run_status |=> snap_b2_r[0] == $past(logic_general_err)
                       && snap_b2_r[1] == $past(logic_image_missing))
        else $error("second byte does not carry fault inputs");
    a_byte2_send: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == ST_BYTE1 && tx_ready) |=> tx_data_r == $past(snap_b2_r))
        else $error("second reply byte not the snapshot");
    a_flag_view: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> camera_error_flags_r == {$past(flags_b2), $past(flags_b1)})
        else $error("register view stale");

    c_status_reply: cover property (@(posedge clk_sys) disable iff (rst)
        run_status ##1 (tx_valid_r && !tx_last_r) ##1 (tx_valid_r && tx_last_r) ##1 !tx_valid_r);
    c_stalled_reply: cover property (@(posedge clk_sys) disable iff (rst)
        tx_valid_r && !tx_ready ##1 tx_valid_r && !tx_ready);
    c_denied: cover property (@(posedge clk_sys) disable iff (rst)
        take && known && !access_ok);
    c_len_err: cover property (@(posedge clk_sys) disable iff (rst)
        take && known && !len_ok);
endmodule : ccsr_status
`default_nettype wire

// *** ccsr_host_model.sv ***
`default_nettype none
module ccsr_host_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // reply byte stream
    input  wire logic       tx_valid_r,
    input  wire logic [7:0] tx_data_r,
    input  wire logic       tx_last_r,
    output var  logic       tx_ready,
    // test control and results
    input  wire logic       stall,
    output var  logic [7:0] got_b1,
    output var  logic [7:0] got_b2,
    output var  int         replies,
    output var  int         order_errs
);
    timeunit 1ns;
    timeprecision 1ps;

    logic have_b1;

    initial begin
        tx_ready = 1'b0;
        replies = 0;
        order_errs = 0;
        have_b1 = 1'b0;
    end

    // takes a byte on each edge where valid meets ready
    always @(posedge clk_sys) begin
        tx_ready <= #1 !stall && !rst;
        if (rst) begin
            have_b1 <= 1'b0;
        end else if (tx_valid_r && tx_ready) begin
            if (!tx_last_r) begin
                got_b1  <= tx_data_r;
                have_b1 <= 1'b1;
            end else begin
                if (!have_b1) order_errs <= order_errs + 1;
                got_b2  <= tx_data_r;
                have_b1 <= 1'b0;
                replies <= replies + 1;
            end
        end
    end
endmodule : ccsr_host_model
`default_nettype wire

// *** test_camera_status_error_report.sv ***
`default_nettype none
module test_camera_status_error_report import ccsr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, rst, cmd_valid, cmd_ready_r, cmd_read, rsp_read_r;
    logic [7:0]  cmd_code, cmd_len, rsp_code_r, rsp_len_r, tx_data_r, faults;
    logic        tx_valid_r, tx_ready, tx_last_r, camera_unlocked, flags_clear;
    logic        external_line_trigger, stall, trig_en;
    logic [15:0] camera_error_flags_r;
    logic [7:0]  got_b1, got_b2, tcnt;
    int          replies, order_errs, fails, samples_checked, n0;
    // unlocked, byte2 faults, expected flags
    logic [24:0] rows [10] = '{
        {1'b0, 8'h01, 16'h0100}, {1'b0, 8'h02, 16'h0200}, {1'b0, 8'h04, 16'h0400},
        {1'b0, 8'h08, 16'h0800}, {1'b0, 8'h10, 16'h1000}, {1'b0, 8'h20, 16'h2000},
        {1'b0, 8'h40, 16'h4000}, {1'b0, 8'h80, 16'h8000}, {1'b1, 8'h00, 16'h0004},
        {1'b1, 8'hA5, 16'hA504}};
    // code, read, length, expected byte 1
    logic [24:0] errs [7] = '{
        {8'h55, 1'b0, 8'h02, 8'h10}, {8'h44, 1'b1, 8'h04, 8'h20},
        {8'h42, 1'b1, 8'h02, 8'h20}, {8'h43, 1'b0, 8'h02, 8'h20},
        {8'h43, 1'b1, 8'h03, 8'h40}, {8'h44, 1'b0, 8'h02, 8'h40},
        {8'h47, 1'b1, 8'h01, 8'h00}};

    ccsr_status #(.TICK_CYCLES(4), .TIMEOUT_TICKS(5)) dut (
        .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready_r(cmd_ready_r),
        .cmd_code(cmd_code), .cmd_read(cmd_read), .cmd_len(cmd_len),
        .rsp_code_r(rsp_code_r), .rsp_read_r(rsp_read_r), .rsp_len_r(rsp_len_r),
        .tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .tx_data_r(tx_data_r),
        .tx_last_r(tx_last_r), .external_line_trigger(external_line_trigger),
        .camera_unlocked(camera_unlocked), .flags_clear(flags_clear),
        .logic_general_err(faults[0]), .logic_image_missing(faults[1]),
        .converter_link_err(faults[2]), .cmd_list_entry_err(faults[3]),
        .user_set_corrupt(faults[4]), .factory_set_corrupt(faults[5]),
        .nvm_checksum_err(faults[6]), .nvm_cmd_list_missing(faults[7]),
        .camera_error_flags_r(camera_error_flags_r));

    ccsr_host_model host (
        .clk_sys(clk_sys), .rst(rst), .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r),
        .tx_last_r(tx_last_r), .tx_ready(tx_ready), .stall(stall), .got_b1(got_b1),
        .got_b2(got_b2), .replies(replies), .order_errs(order_errs));

    // ------------------------------------------------------------------------
    // clock, trigger source, watchdog
    // ------------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        tcnt <= tcnt + 8'h01;
        external_line_trigger <= #1 trig_en && (tcnt[2:0] == 3'h0);
    end

    initial begin
        #20000;
        fails++;
        give_verdict();
    end

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic send(input logic [7:0] c, input logic r, input logic [7:0] l);
        int n;
        n = 0;
        cmd_code = c;
        cmd_read = r;
        cmd_len = l;
        cmd_valid = 1'b1;
        while (cmd_ready_r !== 1'b1 && n < 50) begin
            step(1);
            n++;
        end
        step(1);
        cmd_valid = 1'b0;
        step(1);
    endtask : send

    task automatic query(input logic [15:0] exp);
        int n;
        int m;
        n = replies;
        m = 0;
        send(8'h43, 1'b1, 8'h02);
        while (replies == n && m < 20) begin
            step(1);
            m++;
        end
        chk_bit(1'(replies == n + 1), 1'b1);
        chk_byte(rsp_code_r, 8'h43);
        chk_bit(rsp_read_r, 1'b0);
        chk_byte(rsp_len_r, 8'h02);
        chk_byte(got_b1, exp[7:0]);
        chk_byte(got_b2, exp[15:8]);
    endtask : query

    task automatic clr();
        flags_clear = 1'b1;
        step(1);
        flags_clear = 1'b0;
    endtask : clr

    task automatic give_verdict();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        {rst, trig_en} = 2'b11;
        {cmd_valid, cmd_read, stall, flags_clear, camera_unlocked} = 5'h00;
        {cmd_code, cmd_len, faults, tcnt} = 32'h0000_0000;
        external_line_trigger = 1'b0;
        step(6);
        rst = 1'b0;
        step(2);
        chk_byte(camera_error_flags_r[7:0], 8'h02);
        query(16'h0002);
        clr();
        for (int i = 0; i < 10; i++) begin
            {camera_unlocked, faults} = rows[i][24:16];
            step(2);
            query(rows[i][15:0]);
            chk_byte(camera_error_flags_r[15:8], rows[i][15:8]);
            chk_byte(camera_error_flags_r[7:0], rows[i][7:0]);
        end
        {camera_unlocked, faults} = 9'h000;
        for (int i = 0; i < 7; i++) begin
            clr();
            n0 = replies;
            send(errs[i][24:17], errs[i][16], errs[i][15:8]);
            step(3);
            chk_bit(tx_valid_r, 1'b0);
            chk_bit(1'(replies == n0), 1'b1);
            query({8'h00, errs[i][7:0]});
        end
        query(16'h0000);
        // every flag but reset-seen raised: reserved positions must stay low
        {trig_en, camera_unlocked, faults} = 10'h1FF;
        send(8'h55, 1'b1, 8'h02);
        send(8'h44, 1'b1, 8'h04);
        send(8'h42, 1'b0, 8'h03);
        step(30);
        query(16'hFF75);
        trig_en = 1'b1;
        step(10);
        query(16'hFF34);
        chk_bit(1'(order_errs == 0), 1'b1);
        // stalled reply, then reset in mid reply
        clr();
        faults = 8'h00;
        stall = 1'b1;
        send(8'h43, 1'b1, 8'h02);
        step(4);
        chk_bit(tx_valid_r, 1'b1);
        chk_bit(tx_last_r, 1'b0);
        chk_byte(tx_data_r, 8'h04);
        chk_bit(cmd_ready_r, 1'b0);
        rst = 1'b1;
        step(1);
        rst = 1'b0;
        chk_bit(tx_valid_r, 1'b0);
        chk_bit(cmd_ready_r, 1'b1);
        stall = 1'b0;
        step(2);
        query(16'h0006);
        step(2);
        give_verdict();
    end
endmodule : test_camera_status_error_report
`default_nettype wire
